// [rtl/ppwt_pkg.sv]
// Constants and types for the pin pulse, wave and timing block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package ppwt_pkg;
	// Clock rate in MHz
	localparam int CLK_MHZ = 50;
	// Step of pulse, wait and discharge timing, in us
	localparam int T_STEP_US = 10;
	// Step of the cycles generator, in us
	localparam int T_CYC_US = 3;
	// Granule of the modulator and square wave, in us
	localparam int T_GRAN_US = 25;
	// Charge time before a discharge measurement, in us
	localparam int T_CHARGE_US = 1000;
	// Prescaler reload values, cycles minus one
	localparam logic [10:0] PRE_STEP = 11'(CLK_MHZ * T_STEP_US - 1);
	localparam logic [10:0] PRE_CYC = 11'(CLK_MHZ * T_CYC_US - 1);
	localparam logic [10:0] PRE_GRAN = 11'(CLK_MHZ * T_GRAN_US - 1);
	// Charge time in steps
	localparam logic [15:0] CHARGE_STEPS = 16'(T_CHARGE_US / T_STEP_US);
	// Highest legal pin number
	localparam logic [7:0] PIN_MAX = 8'h0F;
	// Saturation value of word counts
	localparam logic [15:0] WORD_MAX = 16'hFFFF;
	// Full scale of the modulator duty
	localparam logic [8:0] DUTY_FULL = 9'h100;
	// Commands
	typedef enum logic [2:0] {
		PPWT_OP_PULSE = 3'b000,
		PPWT_OP_CYCLES = 3'b001,
		PPWT_OP_PPM = 3'b010,
		PPWT_OP_SQUARE = 3'b011,
		PPWT_OP_WAIT_LOW = 3'b100,
		PPWT_OP_WAIT_HIGH = 3'b101,
		PPWT_OP_DISCHARGE = 3'b110
	} ppwt_op_t;
	// Engine states
	typedef enum logic [2:0] {
		PPWT_S_IDLE = 3'b000,
		PPWT_S_PULSE = 3'b001,
		PPWT_S_CYC = 3'b010,
		PPWT_S_WAVE = 3'b011,
		PPWT_S_WAIT = 3'b100,
		PPWT_S_CHARGE = 3'b101,
		PPWT_S_DISCH = 3'b110
	} ppwt_state_t;
endpackage

// [rtl/ppwt_engine.sv]
// Pin pulse, counted cycles, modulator, square wave and timing engine
`timescale 1ns/1ps
module ppwt_engine #(
	// 1: fast clock variant, modulator keeps background ticks
	parameter bit FAST_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Command request
	input wire logic cmd_start,
	input wire logic [2:0] cmd_op,
	input wire logic [7:0] cmd_pin,
	input wire logic [15:0] cmd_arg_a,
	input wire logic [15:0] cmd_arg_b,
	input wire logic [15:0] cmd_arg_c,
	// Direction load, 1 = output
	input wire logic dir_load,
	input wire logic [15:0] dir_value,
	// General I/O pins
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	// Background real-time tick
	input wire logic rtc_tick_in,
	output logic rtc_tick_out,
	output logic rtc_tick_lost,
	// Command answer
	output logic busy,
	output logic done,
	output logic cmd_err,
	output logic [15:0] result
);
	//------------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------------
	// Trailing zeros of a duty byte, 8 when zero
	function automatic logic [3:0] ppwt_ctz(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				n = 4'(i);
			end
		end
		return n;
	endfunction

	// Prescaler reload for the time step of a state
	function automatic logic [10:0] ppwt_unit(input ppwt_pkg::ppwt_state_t s);
		logic [10:0] u;
		u = ppwt_pkg::PRE_STEP;
		if (s == ppwt_pkg::PPWT_S_CYC) begin
			u = ppwt_pkg::PRE_CYC;
		end else if (s == ppwt_pkg::PPWT_S_WAVE) begin
			u = ppwt_pkg::PRE_GRAN;
		end
		return u;
	endfunction

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	ppwt_pkg::ppwt_state_t st_r, st_nxt; // Engine state
	logic [3:0] sel_r, sel_nxt; // Active pin
	logic [10:0] pre_r, pre_nxt; // Step prescaler
	logic [15:0] ph_r, ph_nxt; // Phase or elapsed count
	logic [15:0] rem_r, rem_nxt; // Periods or granules left
	logic [15:0] hi_r, hi_nxt; // High length
	logic [15:0] lo_r, lo_nxt; // Low length or cycle length
	logic want_r, want_nxt; // Awaited level
	logic ppm_r, ppm_nxt; // Wave is the modulator
	logic [15:0] out_r, out_nxt;
	logic [15:0] oe_r, oe_nxt;
	logic busy_r, done_r, done_nxt, err_r, err_nxt;
	logic [15:0] res_r, res_nxt;
	logic fwd_r, lost_r;

	//------------------------------------------------------------------
	// Decoding
	//------------------------------------------------------------------
	// One step of the current time base elapsed
	wire step_tick = (st_r != ppwt_pkg::PPWT_S_IDLE) && (pre_r == 11'h000);
	wire [15:0] ph_inc = ph_r + 16'h0001;
	wire ph_full = (ph_r == ppwt_pkg::WORD_MAX);
	wire pin_lvl = pin_in[sel_r];
	// Command legality
	wire pin_ok = (cmd_pin <= ppwt_pkg::PIN_MAX);
	wire op_ok = (cmd_op != 3'b111);
	wire [3:0] cmd_sel = cmd_pin[3:0];
	// Modulator: duty/256 reduced to lowest terms
	wire [8:0] duty9 = {1'b0, cmd_arg_a[7:0]};
	wire [8:0] comp9 = ppwt_pkg::DUTY_FULL - duty9;
	wire [3:0] duty_tz = ppwt_ctz(cmd_arg_a[7:0]);
	wire [8:0] ppm_hi = duty9 >> duty_tz;
	wire [8:0] ppm_lo = comp9 >> duty_tz;
	// Square half period in granules
	wire [8:0] sq_half = comp9;
	// Background ticks are dropped during cycles, and during the modulator when not the fast variant
	wire drop_rtc = (st_r == ppwt_pkg::PPWT_S_CYC) ||
		((st_r == ppwt_pkg::PPWT_S_WAVE) && ppm_r && !FAST_VARIANT);

	//------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		ph_nxt = ph_r;
		rem_nxt = rem_r;
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		want_nxt = want_r;
		ppm_nxt = ppm_r;
		out_nxt = out_r;
		oe_nxt = oe_r;
		res_nxt = res_r;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		pre_nxt = step_tick ? ppwt_unit(st_r) : pre_r - 11'h001;
		unique case (st_r)
			ppwt_pkg::PPWT_S_IDLE: begin
				pre_nxt = pre_r;
				// Direction loads are taken only between commands
				if (dir_load) begin
					oe_nxt = dir_value;
				end
				if (cmd_start) begin
					sel_nxt = cmd_sel;
					ph_nxt = 16'h0000;
					if (!pin_ok || !op_ok) begin
						err_nxt = 1'b1;
					end else begin
						unique case (ppwt_pkg::ppwt_op_t'(cmd_op))
							ppwt_pkg::PPWT_OP_PULSE: begin
								rem_nxt = cmd_arg_a;
								if (cmd_arg_a == 16'h0000) begin
									done_nxt = 1'b1;
								end else begin
									out_nxt[cmd_sel] = 1'b1;
									st_nxt = ppwt_pkg::PPWT_S_PULSE;
								end
							end
							ppwt_pkg::PPWT_OP_CYCLES: begin
								// full 16-bit high and cycle times
								rem_nxt = cmd_arg_a;
								hi_nxt = cmd_arg_b;
								lo_nxt = cmd_arg_c;
								if (cmd_arg_a == 16'h0000 ||
									cmd_arg_c == 16'h0000) begin
									done_nxt = 1'b1;
								end else begin
									out_nxt[cmd_sel] = (cmd_arg_b != 16'h0000);
									st_nxt = ppwt_pkg::PPWT_S_CYC;
								end
							end
							ppwt_pkg::PPWT_OP_PPM,
							ppwt_pkg::PPWT_OP_SQUARE: begin
								ppm_nxt = (cmd_op == ppwt_pkg::PPWT_OP_PPM);
								rem_nxt = cmd_arg_b;
								if (cmd_op == ppwt_pkg::PPWT_OP_PPM) begin
									hi_nxt = {7'h00, ppm_hi};
									lo_nxt = {7'h00, ppm_lo};
									out_nxt[cmd_sel] = (cmd_arg_a[7:0] != 8'h00);
								end else begin
									hi_nxt = {7'h00, sq_half};
									lo_nxt = {7'h00, sq_half};
									out_nxt[cmd_sel] = 1'b1;
								end
								if (cmd_arg_b == 16'h0000) begin
									out_nxt[cmd_sel] = out_r[cmd_sel];
									done_nxt = 1'b1;
								end else begin
									st_nxt = ppwt_pkg::PPWT_S_WAVE;
								end
							end
							ppwt_pkg::PPWT_OP_WAIT_LOW,
							ppwt_pkg::PPWT_OP_WAIT_HIGH: begin
								oe_nxt[cmd_sel] = 1'b0;
								want_nxt = cmd_op[0];
								st_nxt = ppwt_pkg::PPWT_S_WAIT;
							end
							ppwt_pkg::PPWT_OP_DISCHARGE: begin
								// Charge the network before timing it
								oe_nxt[cmd_sel] = 1'b1;
								out_nxt[cmd_sel] = 1'b1;
								st_nxt = ppwt_pkg::PPWT_S_CHARGE;
							end
							default: begin
								err_nxt = 1'b1;
							end
						endcase
						st_nxt = err_nxt ? ppwt_pkg::PPWT_S_IDLE : st_nxt;
					end
					if (st_nxt != ppwt_pkg::PPWT_S_IDLE) begin
						pre_nxt = ppwt_unit(st_nxt);
					end
				end
			end
			ppwt_pkg::PPWT_S_PULSE: begin
				// end after dur steps of 10 us
				if (step_tick) begin
					rem_nxt = rem_r - 16'h0001;
					if (rem_r == 16'h0001) begin
						out_nxt[sel_r] = 1'b0;
						done_nxt = 1'b1;
						st_nxt = ppwt_pkg::PPWT_S_IDLE;
					end
				end
			end
			ppwt_pkg::PPWT_S_CYC: begin
				// rate set by 3 us steps
				// high for hi steps of each cycle
				if (step_tick) begin
					if (ph_inc >= lo_r) begin
						ph_nxt = 16'h0000;
						rem_nxt = rem_r - 16'h0001;
						out_nxt[sel_r] = (hi_r != 16'h0000);
						if (rem_r == 16'h0001) begin
							out_nxt[sel_r] = 1'b0;
							done_nxt = 1'b1;
							st_nxt = ppwt_pkg::PPWT_S_IDLE;
						end
					end else begin
						ph_nxt = ph_inc;
						out_nxt[sel_r] = (ph_inc < hi_r);
					end
				end
			end
			ppwt_pkg::PPWT_S_WAVE: begin
				if (step_tick) begin
					rem_nxt = rem_r - 16'h0001;
					ph_nxt = ph_inc;
					// high hi granules, low lo granules
					if (hi_r == 16'h0000) begin
						ph_nxt = 16'h0000;
					end else if (out_r[sel_r] && ph_inc == hi_r) begin
						out_nxt[sel_r] = 1'b0;
						ph_nxt = 16'h0000;
					end else if (!out_r[sel_r] && ph_inc == lo_r) begin
						out_nxt[sel_r] = 1'b1;
						ph_nxt = 16'h0000;
					end
					if (rem_r == 16'h0001) begin
						out_nxt[sel_r] = 1'b0;
						done_nxt = 1'b1;
						st_nxt = ppwt_pkg::PPWT_S_IDLE;
					end
				end
			end
			ppwt_pkg::PPWT_S_WAIT: begin
				// count 10 us steps, hold at maximum
				if (pin_lvl == want_r) begin
					res_nxt = ph_r;
					done_nxt = 1'b1;
					st_nxt = ppwt_pkg::PPWT_S_IDLE;
				end else if (step_tick && !ph_full) begin
					ph_nxt = ph_inc;
				end
			end
			ppwt_pkg::PPWT_S_CHARGE: begin
				if (step_tick) begin
					ph_nxt = ph_inc;
					if (ph_inc == ppwt_pkg::CHARGE_STEPS) begin
						oe_nxt[sel_r] = 1'b0;
						ph_nxt = 16'h0000;
						st_nxt = ppwt_pkg::PPWT_S_DISCH;
					end
				end
			end
			ppwt_pkg::PPWT_S_DISCH: begin
				// zero when too short or too long
				if (!pin_lvl) begin
					res_nxt = ph_r;
					done_nxt = 1'b1;
					st_nxt = ppwt_pkg::PPWT_S_IDLE;
				end else if (step_tick) begin
					ph_nxt = ph_inc;
					if (ph_full) begin
						res_nxt = 16'h0000;
						done_nxt = 1'b1;
						st_nxt = ppwt_pkg::PPWT_S_IDLE;
					end
				end
			end
			default: begin
				st_nxt = ppwt_pkg::PPWT_S_IDLE;
			end
		endcase
	end

	//------------------------------------------------------------------
	// Registers
	//------------------------------------------------------------------
	// Engine and pin registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ppwt_pkg::PPWT_S_IDLE;
			sel_r <= 4'h0;
			pre_r <= 11'h000;
			ph_r <= 16'h0000;
			rem_r <= 16'h0000;
			hi_r <= 16'h0000;
			lo_r <= 16'h0000;
			want_r <= 1'b0;
			ppm_r <= 1'b0;
			out_r <= 16'h0000;
			oe_r <= 16'h0000;
			res_r <= 16'h0000;
			done_r <= 1'b0;
			err_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			pre_r <= pre_nxt;
			ph_r <= ph_nxt;
			rem_r <= rem_nxt;
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
			want_r <= want_nxt;
			ppm_r <= ppm_nxt;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			res_r <= res_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			busy_r <= (st_nxt != ppwt_pkg::PPWT_S_IDLE);
		end
	end

	// Background tick pass-through; cycles cannot spare the time
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_r <= 1'b0;
			lost_r <= 1'b0;
		end else begin
			fwd_r <= rtc_tick_in && !drop_rtc;
			lost_r <= rtc_tick_in && drop_rtc;
		end
	end

	assign pin_out = out_r;
	assign pin_oe = oe_r;
	assign rtc_tick_out = fwd_r;
	assign rtc_tick_lost = lost_r;
	assign busy = busy_r;
	assign done = done_r;
	assign cmd_err = err_r;
	assign result = res_r;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	chk_pulse_high: assert property (
		st_r == ppwt_pkg::PPWT_S_PULSE |-> pin_out[sel_r])
		else $error("pulse pin not high");
	chk_pulse_end: assert property (
		st_r == ppwt_pkg::PPWT_S_PULSE && step_tick && rem_r == 16'h0001
		|=> done && !pin_out[sel_r] && !busy)
		else $error("pulse did not end");
	chk_wait_input: assert property (
		st_r == ppwt_pkg::PPWT_S_WAIT |-> !pin_oe[sel_r])
		else $error("wait pin still driven");
	chk_cyc_level: assert property (
		st_r == ppwt_pkg::PPWT_S_CYC && ph_r >= hi_r |-> !pin_out[sel_r])
		else $error("cycles high too long");
	chk_cyc_drop: assert property (
		st_r == ppwt_pkg::PPWT_S_CYC && rtc_tick_in
		|=> rtc_tick_lost && !rtc_tick_out)
		else $error("cycles tick not dropped");
	chk_ppm_slow: assert property (
		st_r == ppwt_pkg::PPWT_S_IDLE && cmd_start && pin_ok &&
		cmd_op == ppwt_pkg::PPWT_OP_PPM && cmd_arg_a[7:0] == 8'h01 &&
		cmd_arg_b != 16'h0000
		|=> hi_r == 16'h0001 && lo_r == 16'h00FF)
		else $error("modulator low rate wrong");
	chk_wave_end: assert property (
		st_r == ppwt_pkg::PPWT_S_WAVE && step_tick && rem_r == 16'h0001
		|=> done && !busy)
		else $error("wave duration wrong");
	chk_ppm_tick: assert property (
		st_r == ppwt_pkg::PPWT_S_WAVE && ppm_r && rtc_tick_in
		|=> rtc_tick_lost == !FAST_VARIANT)
		else $error("modulator tick handling wrong");
	chk_sq_rate: assert property (
		st_r == ppwt_pkg::PPWT_S_IDLE && cmd_start && pin_ok &&
		cmd_op == ppwt_pkg::PPWT_OP_SQUARE && cmd_arg_b != 16'h0000
		|=> hi_r == lo_r && hi_r == 16'h0100 - 16'($past(cmd_arg_a[7:0])))
		else $error("square half period wrong");
	chk_sq_tick: assert property (
		st_r == ppwt_pkg::PPWT_S_WAVE && !ppm_r && rtc_tick_in
		|=> rtc_tick_out)
		else $error("square dropped a tick");
	chk_rc_range: assert property (
		st_r == ppwt_pkg::PPWT_S_DISCH && pin_lvl && step_tick && ph_full
		|=> done && result == 16'h0000)
		else $error("discharge overflow not zero");
	chk_pin_range: assert property (
		st_r == ppwt_pkg::PPWT_S_IDLE && cmd_start && !pin_ok
		|=> cmd_err && !busy)
		else $error("bad pin accepted");
	chk_wait_sat: assert property (
		st_r == ppwt_pkg::PPWT_S_WAIT && ph_full && pin_lvl != want_r
		|=> ph_r == ppwt_pkg::WORD_MAX)
		else $error("wait count wrapped");

	cov_pulse: cover property (st_r == ppwt_pkg::PPWT_S_PULSE ##1 done);
	cov_cycles: cover property (st_r == ppwt_pkg::PPWT_S_CYC ##1 done);
	cov_wave: cover property (st_r == ppwt_pkg::PPWT_S_WAVE && !ppm_r ##1 done);
	cov_rc: cover property (st_r == ppwt_pkg::PPWT_S_DISCH ##1 done);
endmodule

// [test/ppwt_circuit.sv]
// External circuit model: RC network and level sources on the pins
`timescale 1ns/1ps
module ppwt_circuit (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Device side of the pins
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	// Level that a released pin settles to
	input wire logic [15:0] ext_level,
	// Discharge time of the RC network, in clocks
	input wire logic [31:0] rc_cycles,
	// Level seen by the device
	output logic [15:0] pin_in
);
	// Capacitor charged by the last driven level
	logic [15:0] chg_r;
	// Clocks since the device let go of the pin
	int unsigned age [16];

	// Charge while driven high, then age after release
	always @(posedge clock or posedge sys_rst) begin
		for (int i = 0; i < 16; i++) begin
			if (sys_rst) begin
				chg_r[i] <= 1'b0;
				age[i] <= 0;
			end else if (pin_oe[i]) begin
				chg_r[i] <= pin_out[i];
				age[i] <= 0;
			end else if (age[i] != 32'hFFFF_FFFF) begin
				age[i] <= age[i] + 1;
			end
		end
	end

	// Driven pins echo the device; a charged cap holds high a while
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (chg_r[i] && age[i] < rc_cycles)
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ext_level[i];
		end
	end
endmodule

// [test/ppwt_engine_tb.sv]
// Self-checking testbench of the pin pulse, wave and timing engine
`timescale 1ns/1ps
module ppwt_engine_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clock, sys_rst, cmd_start, dir_load, rtc_tick_in;
	logic [2:0] cmd_op;
	logic [7:0] cmd_pin;
	logic [15:0] cmd_arg_a, cmd_arg_b, cmd_arg_c, dir_value;
	logic [15:0] pin_in, pin_out, pin_oe, result, ext_level;
	logic rtc_tick_out, rtc_tick_lost, busy, done, cmd_err, prev;
	logic [31:0] rc_cycles;
	// Counters of the last run; errors and compares of all runs
	int errors, n_compared, ncyc, hi, rises, oth, nerr, nbusy;
	int n_tin, n_tout, n_lost;

	ppwt_engine dut (.clock(clock), .sys_rst(sys_rst),
		.cmd_start(cmd_start), .cmd_op(cmd_op), .cmd_pin(cmd_pin),
		.cmd_arg_a(cmd_arg_a), .cmd_arg_b(cmd_arg_b),
		.cmd_arg_c(cmd_arg_c), .dir_load(dir_load),
		.dir_value(dir_value), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .rtc_tick_in(rtc_tick_in),
		.rtc_tick_out(rtc_tick_out), .rtc_tick_lost(rtc_tick_lost),
		.busy(busy), .done(done), .cmd_err(cmd_err), .result(result));
	ppwt_circuit ext (.clock(clock), .sys_rst(sys_rst),
		.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
		.rc_cycles(rc_cycles), .pin_in(pin_in));

	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Background tick every 98 clocks, off the sampling edge
	initial begin
		forever begin
			repeat (97) @(negedge clock);
			rtc_tick_in = 1'b1;
			@(negedge clock);
			rtc_tick_in = 1'b0;
		end
	end
	// Tally of ticks serviced and dropped
	always @(posedge clock) begin
		n_tin += rtc_tick_in;
		n_tout += rtc_tick_out;
		n_lost += rtc_tick_lost;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task fail(input string m);
		errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	function automatic bit bad(input bit c);
		n_compared++;
		return c;
	endfunction
	task print_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One command; profiles the selected pin until done or refusal
	task automatic run(input logic [2:0] op, input logic [7:0] pin,
		input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] c, input int lim);
		logic [15:0] sel;
		sel = 16'h0001 << pin[3:0];
		cmd_op = op;
		cmd_pin = pin;
		cmd_arg_a = a;
		cmd_arg_b = b;
		cmd_arg_c = c;
		cmd_start = 1'b1;
		{ncyc, hi, rises, oth, nerr, nbusy, n_tin, n_tout, n_lost} = '0;
		prev = pin_out[pin[3:0]];
		// First sample is the cycle right after the take edge
		do begin
			@(negedge clock);
			if (ncyc == 0)
				cmd_start = 1'b0;
			ncyc++;
			if (pin_out[pin[3:0]] === 1'b1 && prev !== 1'b1)
				rises++;
			if (pin_out[pin[3:0]] === 1'b1)
				hi++;
			prev = pin_out[pin[3:0]];
			if ((pin_out & ~sel) !== 16'h0000)
				oth++;
			if (cmd_err === 1'b1)
				nerr++;
			if (busy === 1'b1)
				nbusy++;
		end while (done !== 1'b1 && nerr == 0 && ncyc < lim);
		if (ncyc >= lim)
			fail("command never completed");
		// Let done fall before the next request is raised
		@(negedge clock);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_setup;
		dir_value = 16'hFFFF;
		dir_load = 1'b1;
		@(negedge clock);
		dir_load = 1'b0;
		@(negedge clock);
		if (bad(pin_oe !== 16'hFFFF)) fail("pins not outputs");
	endtask
	task automatic t_pulse;
		logic [7:0] pins [6] = '{8'h00, 8'h07, 8'h08, 8'h0D, 8'h0E, 8'h0F};
		run(3'h0, 8'h03, 16'h0002, 16'h0000, 16'h0000, 1100);
		if (bad(hi != 1000)) fail("pulse width wrong");
		foreach (pins[i]) begin
			run(3'h0, pins[i], 16'h0001, 16'h0000, 16'h0000, 600);
			if (bad(hi != 500 || oth != 0)) fail("wrong pin");
		end
		run(3'h0, 8'h03, 16'h0000, 16'h0000, 16'h0000, 10);
		if (bad(hi != 0)) fail("zero pulse drove pin");
		run(3'h0, 8'h10, 16'h0001, 16'h0000, 16'h0000, 4);
		if (bad(nerr != 1 || nbusy != 0)) fail("pin 16 taken");
		run(3'h7, 8'h03, 16'h0001, 16'h0000, 16'h0000, 4);
		if (bad(nerr != 1 || nbusy != 0)) fail("op 7 taken");
	endtask
	task t_cycles;
		run(3'h1, 8'h05, 16'h0003, 16'h0002, 16'h0005, 2400);
		if (bad(hi != 900 || rises != 3)) fail("cycle shape");
		if (bad(ncyc != 2251)) fail("cycle period");
		if (bad(hi * 5 < ncyc * 2 - 5)) fail("cycle ratio");
		if (bad(n_lost == 0)) fail("ticks not dropped");
	endtask
	task t_ppm;
		run(3'h2, 8'h06, 16'h0080, 16'h0008, 16'h0000, 10100);
		if (bad(rises != 4)) fail("modulator rate at 128");
		if (bad(hi < 4990 || hi > 5010)) fail("duty 128 level");
		if (bad(ncyc < 10000 || ncyc > 10002)) fail("duration");
		if (bad(n_lost != 0 || n_tout == 0)) fail("ticks lost");
		run(3'h2, 8'h06, 16'h0040, 16'h0008, 16'h0000, 10100);
		if (bad(hi < 2480 || hi > 2520)) fail("duty 64 level");
		// Duty 1 is the slowest rate: one granule high first
		run(3'h2, 8'h06, 16'h0001, 16'h0001, 16'h0000, 1400);
		if (bad(hi != 1250 || rises != 1)) fail("duty 1 shape");
	endtask
	task t_square;
		run(3'h3, 8'h0B, 16'h00FF, 16'h0008, 16'h0000, 10100);
		if (bad(rises != 4 || hi < 4990 || hi > 5010)) fail("square");
		if (bad(n_lost != 0 || n_tout == 0)) fail("ticks lost");
	endtask
	task t_wait;
		fork
			run(3'h5, 8'h09, 16'h0000, 16'h0000, 16'h0000, 6000);
			begin
				repeat (5200) @(negedge clock);
				ext_level[9] = 1'b1;
			end
		join
		if (bad(pin_oe[9] !== 1'b0)) fail("pin not input");
		if (bad(result !== 16'h000A && result !== 16'h000B)) fail("high");
		fork
			run(3'h4, 8'h09, 16'h0000, 16'h0000, 16'h0000, 3000);
			begin
				repeat (2600) @(negedge clock);
				ext_level[9] = 1'b0;
			end
		join
		if (bad(result !== 16'h0005 && result !== 16'h0006)) fail("low");
	endtask
	task t_disch;
		rc_cycles = 32'h0000_07D0;
		run(3'h6, 8'h0E, 16'h0000, 16'h0000, 16'h0000, 53000);
		if (bad(pin_oe[14] !== 1'b0)) fail("discharge pin driven");
		if (bad(result !== 16'h0003 && result !== 16'h0004 &&
			result !== 16'h0005)) fail("discharge count");
	endtask

	// Main sequence; one reset, then every scenario
	initial begin
		{cmd_start, dir_load, rtc_tick_in, cmd_op, cmd_pin} = '0;
		{cmd_arg_a, cmd_arg_b, cmd_arg_c, dir_value} = '0;
		{ext_level, rc_cycles, errors, n_compared} = '0;
		sys_rst = 1'b1;
		repeat (16) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		t_setup;
		t_pulse;
		t_cycles;
		t_ppm;
		t_square;
		t_wait;
		t_disch;
		print_verdict;
	end
	// Watchdog: whole run takes about 97.4k clocks
	initial begin
		repeat (100000) @(posedge clock);
		fail("watchdog expired");
		print_verdict;
	end
endmodule
